// ---- core/sysref_dco_map.vh ----
// Register map, field layout, reset values and timing constants of the SYSREF delay config.
// Overview of operation
// - Two-bit delay multiplier selects 131/262/393/524ps steps.
// - Nine-bit feedback divider, reset 16, multiplies oscillator.
// - Seven-bit input divider, reset 8; software targets nominal.
// - Alignment reference divides input clock by 24 or 48.
// - AC bias: powerdown one-then-zero parks legs at crosspoint.
// - Delay unit equals (1+code) over eight oscillator periods.
// - Global powerdown zero powers SYSREF blocks; one powers down.
`ifndef SYSREF_CFG_MAP_VH
`define SYSREF_CFG_MAP_VH

// Byte addresses of the register words on the APB.
`define ADDR_DELAY_ALIGN 12'h000
`define ADDR_OSC_DIVIDERS 12'h004
`define ADDR_SYSREF_CTRL 12'h008
`define ADDR_STATUS 12'h00c

// Field positions inside the delay and alignment word.
`define MULT_LSB 0
`define MULT_MSB 1
`define ALIGN_SEL_BIT 8

// Field positions inside the oscillator divider word.
`define FBDIV_LSB 0
`define FBDIV_MSB 8
`define INDIV_LSB 16
`define INDIV_MSB 22

// Field positions inside the SYSREF control word.
`define PWRDN_BIT 0
`define BIAS_AC_BIT 1
`define RUN_BIT 2

// Field positions inside the status word.
`define ST_POWERED_BIT 0
`define ST_XPOINT_BIT 1
`define ST_RUNNING_BIT 2
`define ST_STATE_LSB 4
`define ST_STATE_MSB 7

// Reset values.
`define MULT_RESET 2'h0
`define FBDIV_RESET 9'h010
`define INDIV_RESET 7'h08
`define ALIGN_SEL_RESET 1'h0

// Alignment reference division ratios.
`define ALIGN_DIV_SMALL 7'h18
`define ALIGN_DIV_LARGE 7'h30

// Delay step figures in picoseconds at the nominal oscillator rate.
`define DELAY_STEP0_PS 10'h083
`define DELAY_STEP1_PS 10'h106
`define DELAY_STEP2_PS 10'h189
`define DELAY_STEP3_PS 10'h20c
`define DELAY_UNIT_PHASES 4'h8

`endif

// ---- core/enable_divider.v ----
// Programmable clock divider that emits a one-cycle enable pulse.
`default_nettype none
module enable_divider #(
	parameter WIDTH = 7
) (
	input wire clk,
	input wire resetn,
	input wire [WIDTH-1:0] divisor,
	output reg tick_q
);
	reg [WIDTH-1:0] count_q;
	reg [WIDTH-1:0] last_q;
	wire [WIDTH-1:0] last;

	// A divisor of zero behaves as one so the pulse never stops.
	assign last = (divisor == {WIDTH{1'b0}}) ? {WIDTH{1'b0}} : divisor - {{(WIDTH-1){1'b0}}, 1'b1};

	// Count from zero to the latched end point and pulse on the wrap.
	// The end point reloads only at the wrap, so a new divisor never cuts a period short.
	// The end point resets to zero, which gives one early pulse right after reset.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= {WIDTH{1'b0}};
			last_q <= {WIDTH{1'b0}};
			tick_q <= 1'b0;
		end else if (count_q >= last_q) begin
			count_q <= {WIDTH{1'b0}};
			last_q <= last;
			tick_q <= 1'b1;
		end else begin
			count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
			tick_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- core/sysref_delay_dco_divider_config.v ----
// SYSREF delay multiplier, oscillator dividers, alignment divider and leg parking control.
`include "sysref_dco_map.vh"
`default_nettype none
module sysref_delay_dco_divider_config #(
	parameter ADDR_WIDTH = 12
) (
	input wire clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_WIDTH-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg [1:0] sysrefDelayUnitMultiplier,
	output reg [9:0] sysrefDelayStepPs,
	output reg [8:0] oscillatorFeedbackDivider,
	output reg [6:0] oscillatorInputDivider,
	output reg oscillatorPhaseTick,
	output reg alignmentReferenceTick,
	output reg sysrefBlocksPowered,
	output reg sysrefActive,
	output reg sysrefOutputTrueCrosspoint,
	output reg sysrefOutputComplementCrosspoint
);
	// One-hot states of the SYSREF output legs.
	localparam [3:0] LEG_LOW = 4'h1;
	localparam [3:0] LEG_ARMED = 4'h2;
	localparam [3:0] LEG_XPOINT = 4'h4;
	localparam [3:0] LEG_RUN = 4'h8;

	reg [1:0] mult_q;
	reg [8:0] fbDiv_q;
	reg [6:0] inDiv_q;
	reg alignSel_q;
	reg powerdown_q;
	reg biasAc_q;
	reg run_q;
	reg [3:0] legState_q;
	reg [3:0] legState_d;
	reg [31:0] readWord;
	reg addrHit;
	wire setupPhase;
	wire writeStrobe;
	wire [6:0] alignDivisor;
	wire alignTick;
	wire phaseTick;

	// The setup cycle prepares the answer; the access cycle that follows completes it.
	assign setupPhase = psel & ~penable;
	assign writeStrobe = psel & penable & pready & pwrite & ~pslverr;

	// Address decode and read multiplexer; unmapped words read as zero.
	always @* begin
		readWord = 32'h0000_0000;
		addrHit = 1'b1;
		case (paddr)
			`ADDR_DELAY_ALIGN: begin
				readWord[`MULT_MSB:`MULT_LSB] = mult_q;
				readWord[`ALIGN_SEL_BIT] = alignSel_q;
			end
			`ADDR_OSC_DIVIDERS: begin
				readWord[`FBDIV_MSB:`FBDIV_LSB] = fbDiv_q;
				readWord[`INDIV_MSB:`INDIV_LSB] = inDiv_q;
			end
			`ADDR_SYSREF_CTRL: begin
				readWord[`PWRDN_BIT] = powerdown_q;
				readWord[`BIAS_AC_BIT] = biasAc_q;
				readWord[`RUN_BIT] = run_q;
			end
			`ADDR_STATUS: begin
				readWord[`ST_POWERED_BIT] = ~powerdown_q;
				readWord[`ST_XPOINT_BIT] = legState_q[2];
				readWord[`ST_RUNNING_BIT] = legState_q[3];
				readWord[`ST_STATE_MSB:`ST_STATE_LSB] = legState_q;
			end
			default: begin
				addrHit = 1'b0;
			end
		endcase
	end

	// APB answer: pready rises in the access cycle, one cycle after setup, with no wait states.
	// Registering pready costs nothing in latency and keeps every output on a flip-flop.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (setupPhase) begin
			pready <= 1'b1;
			pslverr <= ~addrHit | (pwrite & (paddr == `ADDR_STATUS));
			prdata <= pwrite ? 32'h0000_0000 : readWord;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Configuration registers; writes land at the completing edge of the access phase.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mult_q <= `MULT_RESET;
			fbDiv_q <= `FBDIV_RESET;
			inDiv_q <= `INDIV_RESET;
			alignSel_q <= `ALIGN_SEL_RESET;
			powerdown_q <= 1'b0;
			biasAc_q <= 1'b0;
			run_q <= 1'b0;
		end else if (writeStrobe) begin
			case (paddr)
				`ADDR_DELAY_ALIGN: begin
					mult_q <= pwdata[`MULT_MSB:`MULT_LSB];
					alignSel_q <= pwdata[`ALIGN_SEL_BIT];
				end
				`ADDR_OSC_DIVIDERS: begin
					fbDiv_q <= pwdata[`FBDIV_MSB:`FBDIV_LSB];
					inDiv_q <= pwdata[`INDIV_MSB:`INDIV_LSB];
				end
				`ADDR_SYSREF_CTRL: begin
					powerdown_q <= pwdata[`PWRDN_BIT];
					biasAc_q <= pwdata[`BIAS_AC_BIT];
					run_q <= pwdata[`RUN_BIT];
				end
				default: begin
					mult_q <= mult_q;
				end
			endcase
		end
	end

	// Alignment reference ratio; the hardware does not police the divide-by-16 pairing.
	assign alignDivisor = alignSel_q ? `ALIGN_DIV_LARGE : `ALIGN_DIV_SMALL;

	// Alignment engine reference: one enable pulse per 24 or 48 input clocks.
	enable_divider #(
		.WIDTH(7)
	) alignDivider (
		.clk(clk),
		.resetn(resetn),
		.divisor(alignDivisor),
		.tick_q(alignTick)
	);

	// Oscillator phase detector rate: the input clock divided by the input divider.
	// The feedback multiplication happens in the analog loop, so only the ratio leaves here.
	enable_divider #(
		.WIDTH(7)
	) phaseDivider (
		.clk(clk),
		.resetn(resetn),
		.divisor(inDiv_q),
		.tick_q(phaseTick)
	);

	// Leg state machine.  Power-down with AC bias arms the park; its release parks both legs
	// at the crosspoint level.  Starting generation leaves the park, and halting it drops the
	// legs to a static level until software pulses power-down again.
	always @* begin
		legState_d = legState_q;
		case (legState_q)
			LEG_LOW: begin
				if (powerdown_q && biasAc_q) begin
					legState_d = LEG_ARMED;
				end else if (run_q && !powerdown_q) begin
					legState_d = LEG_RUN;
				end
			end
			LEG_ARMED: begin
				if (!biasAc_q) begin
					legState_d = LEG_LOW;
				end else if (!powerdown_q) begin
					legState_d = LEG_XPOINT;
				end
			end
			LEG_XPOINT: begin
				if (!biasAc_q) begin
					legState_d = LEG_LOW;
				end else if (powerdown_q) begin
					legState_d = LEG_ARMED;
				end else if (run_q) begin
					legState_d = LEG_RUN;
				end
			end
			LEG_RUN: begin
				if (powerdown_q && biasAc_q) begin
					legState_d = LEG_ARMED;
				end else if (powerdown_q || !run_q) begin
					legState_d = LEG_LOW;
				end
			end
			default: begin
				legState_d = LEG_LOW;
			end
		endcase
	end

	// Leg state register.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			legState_q <= LEG_LOW;
		end else begin
			legState_q <= legState_d;
		end
	end

	// Registered outputs; each follows its source one cycle later, save the leg outputs, which take legState_d and change with legState_q.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sysrefDelayUnitMultiplier <= `MULT_RESET;
			sysrefDelayStepPs <= `DELAY_STEP0_PS;
			oscillatorFeedbackDivider <= `FBDIV_RESET;
			oscillatorInputDivider <= `INDIV_RESET;
			oscillatorPhaseTick <= 1'b0;
			alignmentReferenceTick <= 1'b0;
			sysrefBlocksPowered <= 1'b1;
			sysrefActive <= 1'b0;
			sysrefOutputTrueCrosspoint <= 1'b0;
			sysrefOutputComplementCrosspoint <= 1'b0;
		end else begin
			sysrefDelayUnitMultiplier <= mult_q;
			case (mult_q)
				2'h0: sysrefDelayStepPs <= `DELAY_STEP0_PS;
				2'h1: sysrefDelayStepPs <= `DELAY_STEP1_PS;
				2'h2: sysrefDelayStepPs <= `DELAY_STEP2_PS;
				default: sysrefDelayStepPs <= `DELAY_STEP3_PS;
			endcase
			oscillatorFeedbackDivider <= fbDiv_q;
			oscillatorInputDivider <= inDiv_q;
			oscillatorPhaseTick <= phaseTick;
			alignmentReferenceTick <= alignTick;
			sysrefBlocksPowered <= ~powerdown_q;
			sysrefActive <= legState_d[3];
			sysrefOutputTrueCrosspoint <= legState_d[2];
			sysrefOutputComplementCrosspoint <= legState_d[2];
		end
	end
endmodule
`default_nettype wire

// ---- sim/sysref_cfg_props.sv ----
// Concurrent checks on the SYSREF delay and oscillator divider configuration block.
`include "sysref_dco_map.vh"
`default_nettype none
module sysref_cfg_props #(
	parameter ADDR_WIDTH = 12
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] sysrefDelayUnitMultiplier,
	input wire logic [9:0] sysrefDelayStepPs,
	input wire logic [8:0] oscillatorFeedbackDivider,
	input wire logic [6:0] oscillatorInputDivider,
	input wire logic alignmentReferenceTick,
	input wire logic sysrefBlocksPowered,
	input wire logic sysrefActive,
	input wire logic sysrefOutputTrueCrosspoint,
	input wire logic sysrefOutputComplementCrosspoint
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [7:0] gap_q;
	logic seen_q;
	// Only an accepted write may move a register copy.
	wire wr = psel && penable && pready && pwrite && !pslverr;
	// Clocks since the last alignment tick; the first tick after reset has no history.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gap_q <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			gap_q <= alignmentReferenceTick ? 8'h00 : gap_q + 8'h01;
			seen_q <= seen_q | alignmentReferenceTick;
		end
	end
	AST_STEP: assert property (
		sysrefDelayStepPs == 10'h083 * ({8'h00, sysrefDelayUnitMultiplier} + 10'h001))
		else $error("delay step does not follow multiplier");
	AST_FBDIV: assert property (wr && paddr == `ADDR_OSC_DIVIDERS |-> ##2
		{23'h000000, oscillatorFeedbackDivider} == ($past(pwdata, 2) & 32'h000001ff))
		else $error("feedback divider copy wrong");
	AST_INDIV: assert property (wr && paddr == `ADDR_OSC_DIVIDERS |-> ##2
		{9'h000, oscillatorInputDivider, 16'h0000} == ($past(pwdata, 2) & 32'h007f0000))
		else $error("input divider copy wrong");
	AST_PWR: assert property (wr && paddr == `ADDR_SYSREF_CTRL |-> ##2
		{31'h00000000, !sysrefBlocksPowered} == ($past(pwdata, 2) & 32'h00000001))
		else $error("powered flag wrong");
	AST_ALIGN: assert property (
		alignmentReferenceTick && seen_q |-> gap_q == 8'h17 || gap_q == 8'h2f)
		else $error("alignment tick spacing wrong");
	AST_LEGS: assert property (
		sysrefOutputTrueCrosspoint == sysrefOutputComplementCrosspoint)
		else $error("legs differ");
	AST_PARK: assert property (
		$rose(sysrefOutputTrueCrosspoint) |-> sysrefBlocksPowered && !sysrefActive)
		else $error("parked while off or running");
	AST_DOWN: assert property (
		!sysrefBlocksPowered |-> !sysrefActive && !sysrefOutputTrueCrosspoint)
		else $error("active while powered down");
	cover property (alignmentReferenceTick && seen_q && gap_q == 8'h2f);
	cover property ($rose(sysrefOutputTrueCrosspoint));
	cover property ($rose(sysrefActive));
endmodule
bind sysref_delay_dco_divider_config sysref_cfg_props #(.ADDR_WIDTH(ADDR_WIDTH)) props (.clk, .resetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .sysrefDelayUnitMultiplier,
	.sysrefDelayStepPs, .oscillatorFeedbackDivider, .oscillatorInputDivider, .alignmentReferenceTick,
	.sysrefBlocksPowered, .sysrefActive, .sysrefOutputTrueCrosspoint, .sysrefOutputComplementCrosspoint);
`default_nettype wire

// ---- sim/apb_host.sv ----
// Behavioural APB host that writes and reads the configuration words.
`include "sysref_dco_map.vh"
`default_nettype none
module apb_host (
	input wire logic clk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [11:0] paddr,
	output var logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// The bus is idle from time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// One transfer; the request holds until pready is sampled high.
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait as long as the slave needs; only the bench watchdog ends a stuck transfer.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines show the inverse so nothing can lean on stale values.
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	// Powerdown pulse with AC bias held, which parks both legs.
	task park(output logic e);
		logic [31:0] r;
		xfer(1'b1, `ADDR_SYSREF_CTRL, 32'h00000003, r, e);
		xfer(1'b1, `ADDR_SYSREF_CTRL, 32'h00000002, r, e);
	endtask
endmodule
`default_nettype wire

// ---- sim/sysref_delay_dco_divider_config_tb.sv ----
// Self-checking bench for the SYSREF delay and oscillator divider configuration block.
`include "sysref_dco_map.vh"
`default_nettype none
module sysref_delay_dco_divider_config_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic oscillatorPhaseTick, alignmentReferenceTick, sysrefBlocksPowered, sysrefActive;
	logic sysrefOutputTrueCrosspoint, sysrefOutputComplementCrosspoint;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] sysrefDelayUnitMultiplier;
	logic [9:0] sysrefDelayStepPs;
	logic [8:0] oscillatorFeedbackDivider;
	logic [6:0] oscillatorInputDivider;
	int n_errors = 0;
	int num_checks = 0;
	int g;
	sysref_delay_dco_divider_config uut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sysrefDelayUnitMultiplier, .sysrefDelayStepPs,
		.oscillatorFeedbackDivider, .oscillatorInputDivider, .oscillatorPhaseTick,
		.alignmentReferenceTick, .sysrefBlocksPowered, .sysrefActive, .sysrefOutputTrueCrosspoint,
		.sysrefOutputComplementCrosspoint);
	apb_host host (.clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
	// Free-running 50 ns clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task w(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd, err);
		repeat (3) @(posedge clk);
	endtask
	// Clocks between two ticks of the chosen divider, bounded so a dead divider cannot hang.
	task gap(input logic al, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((al ? alignmentReferenceTick : oscillatorPhaseTick) !== 1'b1 && n < 300);
	endtask
	task t_reset;
		chk(32'(sysrefDelayStepPs), 32'h00000083);
		chk(32'(sysrefDelayUnitMultiplier), 32'h00000000);
		chk({16'h0000, oscillatorInputDivider, oscillatorFeedbackDivider}, 32'h00001010);
		chk(32'(sysrefBlocksPowered), 32'h00000001);
		host.xfer(1'b0, `ADDR_OSC_DIVIDERS, 32'h00000000, rd, err);
		chk(rd, 32'h00080010);
		$display("test reset done");
	endtask
	task t_mult;
		for (int c = 0; c < 4; c++) begin
			w(`ADDR_DELAY_ALIGN, 32'(c));
			chk(32'(sysrefDelayStepPs), 32'h00000083 * 32'(c + 1));
			chk(32'(sysrefDelayUnitMultiplier), 32'(c));
		end
		host.xfer(1'b0, `ADDR_DELAY_ALIGN, 32'h00000000, rd, err);
		chk(rd, 32'h00000003);
		$display("test multiplier done");
	endtask
	task t_div;
		w(`ADDR_OSC_DIVIDERS, 32'h007f01ff);
		chk({16'h0000, oscillatorInputDivider, oscillatorFeedbackDivider}, 32'h0000ffff);
		w(`ADDR_OSC_DIVIDERS, 32'h00050010);
		gap(1'b0, g);
		gap(1'b0, g);
		gap(1'b0, g);
		chk(32'(g), 32'h00000005);
		$display("test dividers done");
	endtask
	task t_align;
		w(`ADDR_DELAY_ALIGN, 32'h00000100);
		gap(1'b1, g);
		gap(1'b1, g);
		gap(1'b1, g);
		chk(32'(g), 32'h00000030);
		w(`ADDR_DELAY_ALIGN, 32'h00000000);
		gap(1'b1, g);
		gap(1'b1, g);
		gap(1'b1, g);
		chk(32'(g), 32'h00000018);
		$display("test alignment done");
	endtask
	task t_park;
		w(`ADDR_SYSREF_CTRL, 32'h00000002);
		w(`ADDR_SYSREF_CTRL, 32'h00000003);
		chk(32'(sysrefBlocksPowered), 32'h00000000);
		w(`ADDR_SYSREF_CTRL, 32'h00000002);
		chk({30'h0, sysrefOutputTrueCrosspoint, sysrefOutputComplementCrosspoint}, 32'h3);
		host.xfer(1'b0, `ADDR_STATUS, 32'h00000000, rd, err);
		chk(rd, 32'h00000043);
		w(`ADDR_SYSREF_CTRL, 32'h00000006);
		chk({30'h0, sysrefActive, sysrefOutputTrueCrosspoint}, 32'h2);
		w(`ADDR_SYSREF_CTRL, 32'h00000002);
		chk(32'(sysrefOutputTrueCrosspoint), 32'h00000000);
		host.park(err);
		repeat (3) @(posedge clk);
		chk(32'(sysrefOutputComplementCrosspoint), 32'h00000001);
		$display("test parking done");
	endtask
	task t_err;
		host.xfer(1'b0, 12'h010, 32'h00000000, rd, err);
		chk({err, rd[30:0]}, 32'h80000000);
		host.xfer(1'b1, `ADDR_STATUS, 32'h00000000, rd, err);
		chk(32'(err), 32'h00000001);
		$display("test refusal done");
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Main sequence after ten reset clocks.
	initial begin
		resetn = 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		t_reset;
		t_mult;
		t_div;
		t_align;
		t_park;
		t_err;
		tally_and_finish;
	end
	// The tests need well under a thousand clocks, so this only fires on a hang.
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		$display("Error at %0t: timeout", $time);
		tally_and_finish;
	end
endmodule
`default_nettype wire
